//--- include/prm_pkg.sv
/*
 Constants and types for the system B phase rotation monitor.
 Assumes a 100 MHz system clock and settings held stable by the caller.
*/
package prm_pkg;
	localparam int unsigned CLK_FREQ_HZ      = 100_000_000;
	localparam int unsigned QUAL_DELAY_S     = 2;
	localparam int unsigned QUAL_CYCLES      = QUAL_DELAY_S * CLK_FREQ_HZ;
	localparam int unsigned QUAL_CNT_W       = 28;
	localparam int unsigned LEVEL_W          = 16;
	localparam int unsigned LEVEL_PCT        = 50;
	localparam int unsigned FLAG_COUNT       = 32;
	localparam int unsigned FLAG_SEL_W       = 5;
	localparam logic        RST_MON_ON       = 1'h1;
	localparam logic        RST_ALARM        = 1'h0;

	typedef enum logic {
		ROTATION_FORWARD = 1'h0,
		ROTATION_REVERSE = 1'h1
	} prm_rot_type;

	typedef enum logic [1:0] {
		THREE_PHASE_FOUR_WIRE  = 2'h0,
		THREE_PHASE_THREE_WIRE = 2'h1,
		SINGLE_PHASE_TWO_WIRE  = 2'h2
	} prm_mode_type;

	typedef enum logic [1:0] {
		EN_ALWAYS    = 2'h0,
		EN_MON_LOCK  = 2'h1,
		EN_LOGIC_FLAG = 2'h2
	} prm_en_type;

	typedef enum logic [2:0] {
		CLASS_A       = 3'h0,
		CLASS_B       = 3'h1,
		CLASS_C       = 3'h2,
		CLASS_D       = 3'h3,
		CLASS_E       = 3'h4,
		CLASS_F       = 3'h5,
		CLASS_CONTROL = 3'h6
	} prm_class_type;
endpackage : prm_pkg

//--- src/prm_rotation_monitor.sv
/*
 System B phase rotation monitor: compares the measured phase sequence
 with the expected one, qualifies a mismatch for two seconds and raises a
 latched or self-acknowledging alarm.
 The alarm carries a class that is captured when it rises, so that
 outside logic can decide whether breaker closing is to be blocked.
 A mismatch is reported one cycle late on the pending output.
 Assumes all inputs except the acknowledge button come from logic on
 SYS_CLK; the button is synchronised here.
 Assumes the settings are held stable by the caller while monitoring.
 Assumes the measured and rated voltages use the same unsigned units.
 Assumes a 100 MHz clock, so that the fixed delay spans two seconds.
*/
`timescale 1ns/100ps

// Overview of operation
// - A mismatch between measured and expected rotation raises the alarm.
// - Order L1-L2-L3 counts as forward and L1-L3-L2 as reverse.
// - A raised alarm drives the mismatch message and command variable 06.21.
// - In three-phase modes rotation is judged only above 50 % of rated voltage.
// - In single-phase mode the configured rotation stands in for measurement.
// - With monitoring switched off there is no checking and no alarm.
// - A mismatch must persist for a fixed two seconds before alarming.
// - Expected rotation is forward or reverse, forward by default.
// - The alarm carries one of classes A to F or Control, F by default.
// - With self-acknowledge the alarm clears once the mismatch is gone.
// - Without it the alarm latches until a button or external acknowledge.
// - Enable source always monitors, or monitors until the lock equation.
// - Enable source may pick one of 32 logic flags that gates monitoring.
module prm_rotation_monitor
	import prm_pkg::*;
(
	input  wire logic                  SYS_CLK,
	input  wire logic                  SYS_RST,
	input  wire logic                  MON_ON,
	input  wire logic [1:0]            MEAS_MODE,
	input  wire logic                  SEQ_VALID,
	input  wire logic                  SEQ_L1_L2_L3,
	input  wire logic [LEVEL_W-1:0]    VOLT_MEAS,
	input  wire logic [LEVEL_W-1:0]    VOLT_RATED,
	input  wire logic                  EXPECT_REVERSE,
	input  wire logic                  SINGLE_PHASE_REVERSE,
	input  wire logic [2:0]            ALARM_CLASS,
	input  wire logic                  SELF_ACK,
	input  wire logic [1:0]            ENABLE_SRC,
	input  wire logic                  LOCK_MONITORING,
	input  wire logic [FLAG_COUNT-1:0] LOGIC_FLAG_N,
	input  wire logic [FLAG_SEL_W-1:0] FLAG_SEL,
	input  wire logic                  ACK_BUTTON,
	input  wire logic                  EXT_ACK,
	output logic                       ROTATION_MISMATCH_MESSAGE,
	output logic                       CMD_VAR_06_21,
	output logic [2:0]                 ALARM_CLASS_OUT,
	output logic                       MISMATCH_PENDING
);
	logic                  btn_s1_ff;
	logic                  btn_s2_ff;
	logic                  alarm_ff;
	logic                  nxt_alarm;
	logic [2:0]            class_ff;
	logic [QUAL_CNT_W-1:0] qual_cnt_ff;
	logic                  pending_ff;

	logic [23:0]           level_meas_scaled;
	logic [23:0]           level_rated_scaled;
	logic                  level_ok;
	logic                  measured_rev;
	logic                  judge_ok;
	logic [FLAG_COUNT-1:0] flag_hit;
	logic                  flag_on;
	logic                  enabled;
	logic                  rot_differs;
	logic                  mismatch;

	logic                  qualified;
	logic                  ack;
	logic                  alarm_set;
	logic                  alarm_clr;

	// Counter end point of the qualification delay
	function automatic logic qual_expired(
		input logic [QUAL_CNT_W-1:0] cnt
	);
		qual_expired = (cnt == QUAL_CNT_W'(QUAL_CYCLES - 1));
	endfunction : qual_expired

	// Unused class code falls back to the default class
	function automatic logic [2:0] legal_class(input logic [2:0] cls);
		if (cls > CLASS_CONTROL)
			legal_class = CLASS_F;
		else
			legal_class = cls;
	endfunction : legal_class

	// Acknowledge button arrives from a pin
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			btn_s1_ff <= 1'h0;
			btn_s2_ff <= 1'h0;
		end else begin
			btn_s1_ff <= ACK_BUTTON;
			btn_s2_ff <= btn_s1_ff;
		end
	end

	// Widened compare avoids a divider for the voltage threshold
	assign level_meas_scaled  = {8'h0, VOLT_MEAS} * 24'h64;
	assign level_rated_scaled = {8'h0, VOLT_RATED} * 24'(LEVEL_PCT);
	assign level_ok           = level_meas_scaled > level_rated_scaled;

	// Measured or configured rotation per measuring mode
	always_comb begin
		measured_rev = 1'h0;
		judge_ok     = 1'h0;
		unique case (MEAS_MODE)
			THREE_PHASE_FOUR_WIRE, THREE_PHASE_THREE_WIRE: begin
				measured_rev = ~SEQ_L1_L2_L3;
				judge_ok     = SEQ_VALID & level_ok;
			end
			SINGLE_PHASE_TWO_WIRE: begin
				measured_rev = SINGLE_PHASE_REVERSE;
				judge_ok     = 1'h1;
			end
			default: begin
				measured_rev = 1'h0;
				judge_ok     = 1'h0;
			end
		endcase
	end

	// One select line per logic flag
	genvar gi;
	generate
		for (gi = 0; gi < FLAG_COUNT; gi++) begin : g_flag
			assign flag_hit[gi] = LOGIC_FLAG_N[gi] &&
				(FLAG_SEL == FLAG_SEL_W'(gi));
		end
	endgenerate

	assign flag_on = |flag_hit;

	// Enable source selection
	always_comb begin
		enabled = 1'h0;
		unique case (ENABLE_SRC)
			EN_ALWAYS:     enabled = 1'h1;
			EN_MON_LOCK:   enabled = ~LOCK_MONITORING;
			EN_LOGIC_FLAG: enabled = flag_on;
			default:       enabled = 1'h0;
		endcase
	end

	// Expected rotation compared with measured one
	assign rot_differs = measured_rev != EXPECT_REVERSE;
	assign mismatch    = MON_ON & enabled & judge_ok & rot_differs;

	// Qualification timer restarts whenever the mismatch drops
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST)
			qual_cnt_ff <= '0;
		else if (!mismatch)
			qual_cnt_ff <= '0;
		else if (!qual_expired(qual_cnt_ff))
			qual_cnt_ff <= qual_cnt_ff + 1'b1;
	end

	// Mismatch seen on the previous edge
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST)
			pending_ff <= 1'h0;
		else
			pending_ff <= mismatch;
	end

	assign qualified = mismatch && qual_expired(qual_cnt_ff);
	assign ack       = btn_s2_ff | EXT_ACK;

	// Self-acknowledge clears once the mismatch is gone, latched mode on an acknowledge
	assign alarm_set = qualified;
	assign alarm_clr = SELF_ACK ? !mismatch : ack;

	// Set wins over a clear in the same cycle
	always_comb begin
		nxt_alarm = alarm_ff;
		if (!MON_ON)
			nxt_alarm = 1'h0;
		else if (alarm_set)
			nxt_alarm = 1'h1;
		else if (alarm_clr)
			nxt_alarm = 1'h0;
	end

	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST)
			alarm_ff <= RST_ALARM;
		else
			alarm_ff <= nxt_alarm;
	end

	// Class captured when the alarm rises
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST)
			class_ff <= CLASS_F;
		else if (alarm_set && !alarm_ff)
			class_ff <= legal_class(ALARM_CLASS);
	end

	assign ROTATION_MISMATCH_MESSAGE = alarm_ff;
	assign CMD_VAR_06_21             = alarm_ff;
	assign ALARM_CLASS_OUT           = class_ff;
	assign MISMATCH_PENDING          = pending_ff;
endmodule : prm_rotation_monitor

//--- testbench/prm_asserts.sv
/* Port assertions for the rotation monitor, bound to each instance. */
`timescale 1ns/100ps
module prm_asserts (
	input logic		SYS_CLK,
	input logic		SYS_RST,
	input logic		MON_ON,
	input logic [1:0]	MEAS_MODE,
	input logic		SEQ_VALID,
	input logic [15:0]	VOLT_MEAS,
	input logic [15:0]	VOLT_RATED,
	input logic		ACK_BUTTON,
	input logic		EXT_ACK,
	input logic		SELF_ACK,
	input logic [1:0]	ENABLE_SRC,
	input logic [31:0]	LOGIC_FLAG_N,
	input logic [4:0]	FLAG_SEL,
	input logic		ROTATION_MISMATCH_MESSAGE,
	input logic		CMD_VAR_06_21,
	input logic [2:0]	ALARM_CLASS_OUT,
	input logic		MISMATCH_PENDING
);
	wire logic al = ROTATION_MISMATCH_MESSAGE, pd = MISMATCH_PENDING;
	default clocking dc @(posedge SYS_CLK); endclocking
	default disable iff (SYS_RST);
	property p_cmd; CMD_VAR_06_21 == al; endproperty
	a_cmd: assert property (p_cmd) else $error("cmd var off");
	property p_offp; !MON_ON |=> !pd; endproperty
	a_offp: assert property (p_offp) else $error("pending when off");
	property p_offa; !MON_ON |=> !al; endproperty
	a_offa: assert property (p_offa) else $error("alarm when off");
	property p_rise; $rose(al) |-> $past(pd); endproperty
	a_rise: assert property (p_rise) else $error("early alarm");
	property p_cls; !$rose(al) |-> $stable(ALARM_CLASS_OUT); endproperty
	a_cls: assert property (p_cls) else $error("class moved");
	property p_self; $past(SELF_ACK) && !pd |-> !al; endproperty
	a_self: assert property (p_self) else $error("alarm kept");
	property p_lvl; MEAS_MODE == 3 || MEAS_MODE < 2 && !SEQ_VALID |=> !pd;
	endproperty
	a_lvl: assert property (p_lvl) else $error("judged invalid");
	property p_flag; ENABLE_SRC == 2 && !LOGIC_FLAG_N[FLAG_SEL] |=> !pd;
	endproperty
	a_flag: assert property (p_flag) else $error("flag ignored");
	property p_volt; MEAS_MODE < 2 &&
		({1'b0, VOLT_MEAS} << 1) <= {1'b0, VOLT_RATED} |=> !pd;
	endproperty
	a_volt: assert property (p_volt) else $error("judged low level");
	property p_fall; $fell(al) |-> !$past(MON_ON) || $past(SELF_ACK) ||
		$past(EXT_ACK) || $past(ACK_BUTTON, 2);
	endproperty
	a_fall: assert property (p_fall) else $error("alarm dropped");
endmodule : prm_asserts
bind prm_rotation_monitor prm_asserts prm_asserts_inst (.*);

//--- testbench/prm_rotation_monitor_tb.sv
/* Random bench for the rotation monitor; the checker is bound in. */
`timescale 1ns/100ps
module prm_rotation_monitor_tb;
	logic SYS_CLK = 0, SYS_RST = 1, MON_ON, SEQ_VALID, SEQ_L1_L2_L3;
	logic SELF_ACK, EXPECT_REVERSE, SINGLE_PHASE_REVERSE, LOCK_MONITORING;
	logic EXT_ACK, ACK_BUTTON, ROTATION_MISMATCH_MESSAGE, CMD_VAR_06_21;
	logic MISMATCH_PENDING;
	logic [1:0] MEAS_MODE, ENABLE_SRC;
	logic [2:0] ALARM_CLASS, ALARM_CLASS_OUT;
	logic [4:0] FLAG_SEL;
	logic [15:0] VOLT_MEAS, VOLT_RATED = 16'h96;
	logic [31:0] LOGIC_FLAG_N = 0, r = 0;
	logic q[$];
	int n_errors = 0, cmp_count = 0;
	assign {MON_ON, SEQ_VALID, SEQ_L1_L2_L3, EXPECT_REVERSE, SELF_ACK,
		SINGLE_PHASE_REVERSE, LOCK_MONITORING, ACK_BUTTON, EXT_ACK, MEAS_MODE,
		ENABLE_SRC, ALARM_CLASS, FLAG_SEL} = r[20:0];
	assign VOLT_MEAS = 16'h40 + 16'(r[25:21]);
	prm_rotation_monitor prm_rotation_monitor_inst (.*);
	initial forever #5 SYS_CLK = ~SYS_CLK;
	task chk(string s, logic [2:0] e, logic [2:0] g);
		cmp_count++;
		n_errors += int'(g !== e);
		if (g !== e) $display("mismatch %s exp %h got %h", s, e, g);
	endtask : chk
	task stop_test();
		$display("%0d compares, %0d mismatches", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : stop_test
	task step(int n, logic rst);
		for (int i = 0; i < n; i++) begin
			@(posedge SYS_CLK);
			SYS_RST <= rst;
			if (i % 8 == 0) r <= $urandom;
			LOGIC_FLAG_N <= $urandom;
			#1 q.push_back(!SYS_RST && MON_ON &&
				EXPECT_REVERSE != (MEAS_MODE == 2 ?
				SINGLE_PHASE_REVERSE : !SEQ_L1_L2_L3) && (MEAS_MODE == 2 ||
				MEAS_MODE < 2 && SEQ_VALID && VOLT_MEAS * 2 > VOLT_RATED) &&
				(ENABLE_SRC == 0 || ENABLE_SRC == 1 && !LOCK_MONITORING ||
				ENABLE_SRC == 2 && LOGIC_FLAG_N[FLAG_SEL]));
		end
		$display("random run of %0d cycles done", n);
	endtask : step
	wire logic [1:0] al_o = {ROTATION_MISMATCH_MESSAGE, CMD_VAR_06_21};
	wire logic pd_o = MISMATCH_PENDING;
	always @(negedge SYS_CLK)
		if (q.size() == 2) begin
			chk("outputs", {2'h0, q.pop_front()}, {al_o, pd_o});
			chk("class", 3'h5, ALARM_CLASS_OUT);
		end
	initial begin
		void'($urandom(25729));
		repeat (10) @(posedge SYS_CLK);
		SYS_RST <= 0;
		@(negedge SYS_CLK);
		chk("class", 3'h5, ALARM_CLASS_OUT);
		chk("alarm", 3'h0, {2'h0, ROTATION_MISMATCH_MESSAGE});
		$display("reset done");
		step(1500, 1'b0);
		step(10, 1'b1);
		step(1500, 1'b0);
		stop_test();
	end
	initial begin
		#40000;
		n_errors++;
		stop_test();
	end
endmodule : prm_rotation_monitor_tb
